// ===== inc/root_hub_pkg.sv
// constants and carrier types for the root hub register slice
package root_hub_pkg;
  // command codes on the shared processor bus
  localparam logic [7:0] CODE_DESC_SECOND_RD = 8'h13;
  localparam logic [7:0] CODE_DESC_SECOND_WR = 8'h93;
  localparam logic [7:0] CODE_STATUS_RD = 8'h14;
  localparam logic [7:0] CODE_STATUS_WR = 8'h94;
  // field positions, second descriptor register
  localparam int REMOVABLE_LSB = 0;
  localparam int POWER_MASK_LSB = 16;
  // field positions, root hub status register
  localparam int STATUS_HALF_W = 16;
  localparam int OVERCURRENT_BIT = 1;
  localparam int WAKEUP_ENABLE_BIT = 15;
  localparam int POWER_CHANGE_BIT = 16;
  localparam int OVERCURRENT_CHANGE_BIT = 17;
  localparam int CLEAR_WAKEUP_BIT = 31;
  // reset value of the status register flags, and the all-zero word the read images start from
  localparam logic RESET_FLAG = 1'b0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // one command beat from the processor bus
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [31:0] wdata;
  } cmd_t;

  // read answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } rsp_t;
endpackage

// ===== src/root_hub_regs.sv
// root hub descriptor-second and status registers behind the command port
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - three-bit removable field sits in bits 2..0; bits 15..3 reserved.
// - removable bit zero means removable device, one means fixed device.
// - field bit 0 reserved; bit 1 is port one, bit 2 port two.
// - status register read with code 14h, written with code 94h.
// - status register 32 bits: low half status, high half status change.
// - descriptor-second read with 13h, written with 93h, set at initialization.
//////////////////////////////////////////////////////////////////////////////
module root_hub_regs #(
  parameter int NUM_PORTS = 2,
  parameter logic [NUM_PORTS:0] REMOVABLE_INIT = '0,
  parameter logic [NUM_PORTS:0] POWER_MASK_INIT = '0
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire root_hub_pkg::cmd_t i_cmd,
  input wire logic i_overcurrent_pin,
  input wire logic i_power_change,
  output root_hub_pkg::rsp_t o_rsp,
  output logic [NUM_PORTS:0] o_removable_port_mask,
  output logic [NUM_PORTS:0] o_port_power_mask,
  output logic o_remote_wakeup_enable
);

  // field width must fit below the reserved upper bits of each half
  if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 15");
  end

  localparam int FW = NUM_PORTS + 1;

  //////////////////////////////////////////////////////////////////////////////
  // command decode
  wire rd_desc = i_cmd.valid && i_cmd.code == root_hub_pkg::CODE_DESC_SECOND_RD;
  wire wr_desc = i_cmd.valid && i_cmd.code == root_hub_pkg::CODE_DESC_SECOND_WR;
  wire rd_status = i_cmd.valid && i_cmd.code == root_hub_pkg::CODE_STATUS_RD;
  wire wr_status = i_cmd.valid && i_cmd.code == root_hub_pkg::CODE_STATUS_WR;
  wire [FW-1:0] wr_removable = i_cmd.wdata[root_hub_pkg::REMOVABLE_LSB +: FW];
  wire [FW-1:0] wr_power_mask = i_cmd.wdata[root_hub_pkg::POWER_MASK_LSB +: FW];

  //////////////////////////////////////////////////////////////////////////////
  // overcurrent pin synchroniser; only the second stage is read
  logic oc_meta;
  logic oc_sync;
  logic oc_prev;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oc_meta <= 1'b0;
      oc_sync <= 1'b0;
      oc_prev <= 1'b0;
    end else if (i_ce) begin
      oc_meta <= i_overcurrent_pin;
      oc_sync <= oc_meta;
      oc_prev <= oc_sync;
    end
  end
  wire oc_edge = oc_sync ^ oc_prev;

  //////////////////////////////////////////////////////////////////////////////
  // per-port removable and power-mask bits; bit 0 is reserved, held at zero
  logic [FW-1:0] removable;
  logic [FW-1:0] power_mask;
  assign removable[0] = 1'b0;
  assign power_mask[0] = 1'b0;
  for (genvar p = 1; p < FW; p++) begin : g_port
    // one means the device on port p is fixed, zero means removable
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        removable[p] <= REMOVABLE_INIT[p];
        power_mask[p] <= POWER_MASK_INIT[p];
      end else if (i_ce && wr_desc) begin
        removable[p] <= wr_removable[p];
        power_mask[p] <= wr_power_mask[p];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags: change bits are sticky, write one clears, a new event wins
  // write strobes for the single-bit status commands
  wire wr_set_wakeup = wr_status && i_cmd.wdata[root_hub_pkg::WAKEUP_ENABLE_BIT];
  wire wr_clear_wakeup = wr_status && i_cmd.wdata[root_hub_pkg::CLEAR_WAKEUP_BIT];
  wire wr_clear_power = wr_status && i_cmd.wdata[root_hub_pkg::POWER_CHANGE_BIT];
  wire wr_clear_oc = wr_status && i_cmd.wdata[root_hub_pkg::OVERCURRENT_CHANGE_BIT];
  logic wakeup_enable;
  logic power_change_flag;
  logic overcurrent_change;
  // clear beats set, so one write holding both bits leaves wakeup off
  wire next_wakeup_enable = wr_clear_wakeup ? 1'b0 : wr_set_wakeup ? 1'b1 : wakeup_enable;
  // event beats clear: a change landing with its own clear is never lost
  wire next_power_change_flag = i_power_change ? 1'b1 : wr_clear_power ? 1'b0 : power_change_flag;
  wire next_overcurrent_change = oc_edge ? 1'b1 : wr_clear_oc ? 1'b0 : overcurrent_change;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wakeup_enable <= root_hub_pkg::RESET_FLAG;
      power_change_flag <= root_hub_pkg::RESET_FLAG;
      overcurrent_change <= root_hub_pkg::RESET_FLAG;
    end else if (i_ce) begin
      wakeup_enable <= next_wakeup_enable;
      power_change_flag <= next_power_change_flag;
      overcurrent_change <= next_overcurrent_change;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read images; everything not named stays zero, incl. write-only clear bit
  logic [31:0] desc_image;
  logic [31:0] status_image;
  always_comb begin
    desc_image = root_hub_pkg::ZERO_WORD;
    desc_image[root_hub_pkg::REMOVABLE_LSB +: FW] = removable;
    desc_image[root_hub_pkg::POWER_MASK_LSB +: FW] = power_mask;
    status_image = root_hub_pkg::ZERO_WORD;
    // low half: hub status, high half: hub status change
    status_image[root_hub_pkg::OVERCURRENT_BIT] = oc_sync;
    status_image[root_hub_pkg::WAKEUP_ENABLE_BIT] = wakeup_enable;
    status_image[root_hub_pkg::POWER_CHANGE_BIT] = power_change_flag;
    status_image[root_hub_pkg::OVERCURRENT_CHANGE_BIT] = overcurrent_change;
  end
  wire [31:0] rd_mux = rd_desc ? desc_image : status_image;

  //////////////////////////////////////////////////////////////////////////////
  // answer registered one cycle after the read code is taken
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rsp <= '0;
    end else if (i_ce) begin
      o_rsp.valid <= rd_desc || rd_status;
      if (rd_desc || rd_status) begin
        o_rsp.data <= rd_mux;
      end
    end
  end

  assign o_removable_port_mask = removable;
  assign o_port_power_mask = power_mask;
  assign o_remote_wakeup_enable = wakeup_enable;

  //////////////////////////////////////////////////////////////////////////////
  // checks; one clock domain, so the defaults carry clock and reset
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // command steps: the taking edge, then the answer one edge later
  sequence s_status_read;
    i_ce && rd_status;
  endsequence
  sequence s_desc_read;
    i_ce && rd_desc;
  endsequence
  sequence s_any_write;
    i_ce && (wr_desc || wr_status);
  endsequence
  sequence s_answer;
    o_rsp.valid;
  endsequence
  sequence s_no_answer;
    !o_rsp.valid;
  endsequence
  // synchroniser step: a new level waits in the first stage
  sequence s_meta_differs;
    i_ce && oc_meta != oc_sync;
  endsequence

  // answer timing and contents
  a_status_read_answer: assert property (s_status_read |=> s_answer)
    else $error("status read not answered next cycle");
  a_status_read_data: assert property (s_status_read |=> o_rsp.data == $past(status_image))
    else $error("status read returned wrong data");
  a_desc_read_answer: assert property (s_desc_read |=> o_rsp.valid && o_rsp.data == $past(desc_image))
    else $error("descriptor read returned wrong data");
  a_write_no_answer: assert property (s_any_write |=> s_no_answer)
    else $error("write produced an answer");
  a_idle_no_answer: assert property (i_ce && !rd_desc && !rd_status |=> s_no_answer)
    else $error("answer without a read");
  a_off_holds_answer: assert property (!i_ce |=> $stable(o_rsp))
    else $error("answer moved while clock enable low");

  // reserved positions read zero whatever was written
  a_reserved_bit_zero: assert property (removable[0] == 1'b0 && desc_image[15:FW] == '0)
    else $error("reserved removable bits not zero");
  a_power_bit_zero: assert property (power_mask[0] == 1'b0)
    else $error("reserved power mask bit not zero");
  a_desc_upper_zero: assert property ((desc_image >> (root_hub_pkg::POWER_MASK_LSB + FW)) == '0)
    else $error("reserved descriptor upper bits not zero");
  a_status_reserved: assert property (s_status_read |=> o_rsp.data[30:18] == '0 && o_rsp.data[14:2] == '0)
    else $error("reserved status bits read nonzero");
  a_clear_reads_zero: assert property (s_status_read |=> !o_rsp.data[root_hub_pkg::CLEAR_WAKEUP_BIT])
    else $error("write-only clear bit read nonzero");

  // descriptor-second fields change only on their own write
  a_removable_write: assert property (i_ce && wr_desc |=> removable[FW-1:1] == $past(wr_removable[FW-1:1]))
    else $error("removable field did not take written value");
  a_removable_hold: assert property (i_ce && !wr_desc |=> $stable(removable))
    else $error("removable field changed without write");
  a_power_write: assert property (i_ce && wr_desc |=> power_mask[FW-1:1] == $past(wr_power_mask[FW-1:1]))
    else $error("power mask did not take written value");
  a_power_hold: assert property (i_ce && !wr_desc |=> $stable(power_mask))
    else $error("power mask changed without write");

  // status flags: set, clear and priority
  a_wakeup_sets: assert property (i_ce && wr_set_wakeup && !wr_clear_wakeup |=> wakeup_enable)
    else $error("wakeup enable not set by write");
  a_wakeup_clears: assert property (i_ce && wr_clear_wakeup |=> !wakeup_enable)
    else $error("clear remote wakeup did not clear enable");
  a_wakeup_hold: assert property (i_ce && !wr_status |=> $stable(wakeup_enable))
    else $error("wakeup enable changed without write");
  a_change_set_wins: assert property (i_ce && i_power_change |=> power_change_flag)
    else $error("power change event lost");
  a_change_clears: assert property (i_ce && wr_clear_power && !i_power_change |=> !power_change_flag)
    else $error("power change flag not cleared");
  a_sync_two_stage: assert property (s_meta_differs |=> oc_edge)
    else $error("synchronised level change not seen");
  a_overcurrent_flagged: assert property (i_ce && oc_edge |=> overcurrent_change)
    else $error("overcurrent change not flagged");
  a_overcurrent_clears: assert property (i_ce && wr_clear_oc && !oc_edge |=> !overcurrent_change)
    else $error("overcurrent change flag not cleared");
  a_flags_hold_off: assert property (!i_ce |=>
    $stable({wakeup_enable, power_change_flag, overcurrent_change, oc_meta}))
    else $error("flags moved while clock enable low");

endmodule

// ===== tb/root_hub_regs_tb.sv
// self-checking bench for the root hub register slice
`timescale 1ns/1ps
module root_hub_regs_tb;
  logic i_clk, i_rstn, i_ce, i_overcurrent_pin, i_power_change;
  root_hub_pkg::cmd_t i_cmd;
  root_hub_pkg::rsp_t o_rsp;
  logic [2:0] o_removable_port_mask, o_port_power_mask;
  logic o_remote_wakeup_enable;
  int bad_count = 0;
  int check_count = 0;
  root_hub_regs u_root_hub_regs (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_cmd(i_cmd),
    .i_overcurrent_pin(i_overcurrent_pin), .i_power_change(i_power_change), .o_rsp(o_rsp),
    .o_removable_port_mask(o_removable_port_mask), .o_port_power_mask(o_port_power_mask),
    .o_remote_wakeup_enable(o_remote_wakeup_enable));
  // 250 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // one command beat, released at the edge that takes it
  task automatic send(input logic [7:0] c, input logic [31:0] d);
    @(posedge i_clk);
    i_cmd <= {1'b1, c, d};
    @(posedge i_clk);
    i_cmd <= '0;
    #1;
  endtask
  // answer stands for one cycle only, so look right after the taking edge
  task automatic rd(input logic [7:0] c, input logic [31:0] exp);
    send(c, 32'h0000_0000);
    chk("rsp valid", 32'h0000_0001, {31'h0, o_rsp.valid});
    chk("rsp data", exp, o_rsp.data);
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(root_hub_pkg::CODE_DESC_SECOND_RD, 32'h0000_0000);
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0000_0000);
    chk("removable mask", 32'h0, {29'h0, o_removable_port_mask});
  endtask
  // all ones: only bits 2..1 and 18..17 may stick
  task automatic t_desc;
    send(root_hub_pkg::CODE_DESC_SECOND_WR, 32'hffff_ffff);
    chk("removable mask", 32'h6, {29'h0, o_removable_port_mask});
    chk("power mask", 32'h6, {29'h0, o_port_power_mask});
    rd(root_hub_pkg::CODE_DESC_SECOND_RD, 32'h0006_0006);
    send(root_hub_pkg::CODE_DESC_SECOND_WR, 32'h0000_0002);
    chk("removable mask", 32'h2, {29'h0, o_removable_port_mask});
    chk("power mask", 32'h0, {29'h0, o_port_power_mask});
  endtask
  task automatic t_wake;
    send(root_hub_pkg::CODE_STATUS_WR, 32'h1 << root_hub_pkg::WAKEUP_ENABLE_BIT);
    chk("wakeup enable", 32'h1, {31'h0, o_remote_wakeup_enable});
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0000_8000);
    send(root_hub_pkg::CODE_STATUS_WR, 32'h8000_0000);
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0000_0000);
  endtask
  task automatic t_change;
    @(posedge i_clk);
    i_power_change <= 1'b1;
    @(posedge i_clk);
    i_power_change <= 1'b0;
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0001_0000);
    send(root_hub_pkg::CODE_STATUS_WR, 32'h0001_0000);
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0000_0000);
    // event and clear on one edge: the event must win
    @(posedge i_clk);
    i_power_change <= 1'b1;
    i_cmd <= {1'b1, root_hub_pkg::CODE_STATUS_WR, 32'h0001_0000};
    @(posedge i_clk);
    i_power_change <= 1'b0;
    i_cmd <= '0;
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0001_0000);
    send(root_hub_pkg::CODE_STATUS_WR, 32'h0001_0000);
  endtask
  // pin passes a two-stage synchroniser, so allow a few cycles
  task automatic t_oc;
    @(posedge i_clk);
    i_overcurrent_pin <= 1'b1;
    repeat (5) @(posedge i_clk);
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0002_0002);
    send(root_hub_pkg::CODE_STATUS_WR, 32'h0002_0000);
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0000_0002);
    @(posedge i_clk);
    i_overcurrent_pin <= 1'b0;
    repeat (5) @(posedge i_clk);
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0002_0000);
  endtask
  // disabled clock and unknown codes leave the registers alone
  task automatic t_refuse;
    @(posedge i_clk);
    i_ce <= 1'b0;
    send(root_hub_pkg::CODE_DESC_SECOND_WR, 32'h0000_0004);
    @(posedge i_clk);
    i_ce <= 1'b1;
    send(8'h95, 32'h0000_0004);
    chk("removable mask", 32'h2, {29'h0, o_removable_port_mask});
    chk("rsp valid", 32'h0, {31'h0, o_rsp.valid});
  endtask
  // reset in mid-run brings back the initial values
  task automatic t_rerun;
    send(root_hub_pkg::CODE_STATUS_WR, 32'h0000_8000);
    chk("wakeup enable", 32'h1, {31'h0, o_remote_wakeup_enable});
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(root_hub_pkg::CODE_STATUS_RD, 32'h0000_0000);
    chk("wakeup enable", 32'h0, {31'h0, o_remote_wakeup_enable});
    chk("removable mask", 32'h0, {29'h0, o_removable_port_mask});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rstn = 1'b0;
    i_ce = 1'b1;
    i_cmd = '0;
    i_overcurrent_pin = 1'b0;
    i_power_change = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset;
    t_desc;
    t_wake;
    t_change;
    t_oc;
    t_refuse;
    t_rerun;
    tally_and_finish;
  end
  // whole run is well under a thousand cycles
  initial begin
    #20000;
    bad_count++;
    tally_and_finish;
  end
endmodule
